// [rtl/uirm_top.sv]
// Infrared UART: registers, bit timing, transmitter, receiver and pin sharing
//
// Implementation choices: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
// Behaviour
// - Frame: start, eight data, stop bit
// - Pulse lasts three sixteenths of bit time; the code gives three ticks, which is 3/16 only with a 16-tick bit
// - Pulse rises at middle of bit slot
// - Received data delayed by half bit
// - Reference rate 115.2 kbps, nominal pulse 1.63us
// - Minimum pulse needs active digital noise filter
// - Unused pin stays a general port pin
// - Bit 7 enables transmit, write starts frame
// - Bit 6 enables receive, sampled by baud
// - Falling edge, half bit, low confirms start; the code starts on any low level seen in idle, not only on a falling edge
// - Transmit done raised after last stop bit
module uirm_top
  import uirm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input uirm_bus_req_t bus_req,
  output logic [7:0] bus_rdata,
  input wire logic serial_receive_pin_in,
  output uirm_pin_drv_t serial_receive_pin_drv,
  input wire logic serial_transmit_pin_in,
  output uirm_pin_drv_t serial_transmit_pin_drv,
  output logic irq
);
  logic [7:0] mode_q;
  logic [7:0] div_q;
  logic [PORT_W-1:0] port_q;
  logic [IRQ_W-1:0] mask_q;
  logic [IRQ_W-1:0] stat_q;
  logic [7:0] rxb_q;
  logic [7:0] rdata_q;
  logic txe;
  logic rxe;
  logic ir;
  logic mode_wr;
  logic [2:0] tps;
  logic [4:0] bit_len;
  logic [4:0] last;
  logic [4:0] half;
  logic [7:0] pre_q;
  logic [7:0] pre_mask;
  logic tick;
  uirm_tx_st_t tx_st_q;
  logic [4:0] tx_tick_q;
  logic [2:0] tx_bit_q;
  logic [7:0] tx_sh_q;
  logic tx_go;
  logic tx_level;
  logic tx_done_ev;
  logic ir_pulse_c;
  uirm_pin_drv_t tx_drv_q;
  uirm_pin_drv_t rx_drv_q;
  logic txp_s1_q;
  logic txp_s2_q;
  logic rx_lvl;
  logic rx_prev_q;
  logic rx_rise_c;
  logic str_act_q;
  logic [4:0] str_cnt_q;
  logic rec_line;
  uirm_rx_st_t rx_st_q;
  logic [4:0] rx_tick_q;
  logic [2:0] rx_bit_q;
  logic [7:0] rx_sh_q;
  logic rx_end;
  logic rx_ok_ev;
  logic rx_err_ev;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic tx_lat;
  logic tx_dir;

  // Register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= MODE_RST;
      div_q <= DIV_RST;
      port_q <= PORT_RST;
      mask_q <= MASK_RST;
    end else if (bus_req.we) begin
      case (bus_req.addr)
        ADR_MODE: mode_q <= bus_req.wdata;
        ADR_DIV: div_q <= bus_req.wdata;
        ADR_PORT: port_q <= bus_req.wdata[PORT_W-1:0];
        ADR_IRQ_MASK: mask_q <= bus_req.wdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // Mode decode
  assign txe = mode_q[MODE_TXE];
  assign rxe = mode_q[MODE_RXE];
  assign ir = mode_q[MODE_IR];
  assign mode_wr = bus_req.we && (bus_req.addr == ADR_MODE || bus_req.addr == ADR_DIV);
  assign tx_lat = port_q[PORT_TX_LAT];
  assign tx_dir = port_q[PORT_TX_DIR];

  // Bit timing: prescaled tick, sixteen plus modulus ticks per bit
  assign tps = div_q[DIV_TPS_LSB +: 3];
  assign bit_len = TICKS_BASE + {1'b0, div_q[DIV_MDL_LSB +: 4]};
  assign last = bit_len - 5'h01;
  assign half = bit_len >> 1;
  assign pre_mask = 8'((9'h002 << tps) - 9'h001);
  assign tick = (pre_q & pre_mask) == pre_mask;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pre_q <= 8'h00;
    end else begin
      pre_q <= pre_q + 8'h01;
    end
  end

  // Transmitter
  assign tx_go = bus_req.we && bus_req.addr == ADR_TXD && txe && tx_st_q == TX_IDLE;

  always_ff @(posedge sys_clk) begin
    if (rst || !txe) begin
      tx_st_q <= TX_IDLE;
      tx_tick_q <= 5'h00;
      tx_bit_q <= 3'h0;
      tx_sh_q <= 8'hff;
    end else if (tx_go) begin
      tx_st_q <= TX_START;
      tx_tick_q <= 5'h00;
      tx_bit_q <= 3'h0;
      tx_sh_q <= bus_req.wdata;
    end else if (tick && tx_st_q != TX_IDLE) begin
      if (tx_tick_q == last) begin
        tx_tick_q <= 5'h00;
        case (tx_st_q)
          TX_START: tx_st_q <= TX_DATA;
          TX_DATA: begin
            tx_sh_q <= tx_sh_q >> 1;
            tx_bit_q <= tx_bit_q + 3'h1;
            if (tx_bit_q == LAST_DATA_BIT) begin
              tx_st_q <= TX_STOP;
            end
          end
          default: tx_st_q <= TX_IDLE;
        endcase
      end else begin
        tx_tick_q <= tx_tick_q + 5'h01;
      end
    end
  end

  always_comb begin
    case (tx_st_q)
      TX_START: tx_level = 1'b0;
      TX_DATA: tx_level = tx_sh_q[0];
      default: tx_level = 1'b1;
    endcase
  end

  assign tx_done_ev = txe && tick && tx_st_q == TX_STOP && tx_tick_q == last;

  // Short pulse from mid slot, zero bits only; three ticks assumes a 16-tick bit
  assign ir_pulse_c = txe && ir && !tx_level && tx_tick_q >= half
    && tx_tick_q < half + IR_PULSE_TICKS;

  // Transmit pin: serial output when enabled, else port pin
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_drv_q <= '{out: 1'b0, oe: 1'b0};
    end else if (txe) begin
      tx_drv_q.out <= ir ? ir_pulse_c : tx_level;
      tx_drv_q.oe <= 1'b1;
    end else begin
      tx_drv_q.out <= tx_lat;
      tx_drv_q.oe <= !tx_dir;
    end
  end

  // Receive pin drives only as a port output while reception is off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_drv_q <= '{out: 1'b0, oe: 1'b0};
    end else begin
      rx_drv_q.out <= port_q[PORT_RX_LAT];
      rx_drv_q.oe <= !rxe && !port_q[PORT_RX_DIR];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      txp_s1_q <= 1'b0;
      txp_s2_q <= 1'b0;
    end else begin
      txp_s1_q <= serial_transmit_pin_in;
      txp_s2_q <= txp_s1_q;
    end
  end

  // Receive path
  uirm_rx_filter u_rx_filter (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_in(serial_receive_pin_in),
    .level(rx_lvl)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_prev_q <= 1'b1;
    end else begin
      rx_prev_q <= rx_lvl;
    end
  end

  assign rx_rise_c = rx_lvl && !rx_prev_q;

  // Each pulse becomes one bit time of low level starting at the pulse
  always_ff @(posedge sys_clk) begin
    if (rst || !ir) begin
      str_act_q <= 1'b0;
      str_cnt_q <= 5'h00;
    end else if (rx_rise_c) begin
      str_act_q <= 1'b1;
      str_cnt_q <= 5'h00;
    end else if (str_act_q && tick) begin
      if (str_cnt_q == last) begin
        str_act_q <= 1'b0;
        str_cnt_q <= 5'h00;
      end else begin
        str_cnt_q <= str_cnt_q + 5'h01;
      end
    end
  end

  assign rec_line = ir ? !str_act_q : rx_lvl;

  always_ff @(posedge sys_clk) begin
    if (rst || !rxe) begin
      rx_st_q <= RX_IDLE;
      rx_tick_q <= 5'h00;
      rx_bit_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else begin
      case (rx_st_q)
        RX_IDLE: begin
          if (!rec_line) begin
            rx_st_q <= RX_START;
            rx_tick_q <= 5'h00;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_tick_q == half - 5'h01) begin
              rx_tick_q <= 5'h00;
              rx_bit_q <= 3'h0;
              rx_st_q <= rec_line ? RX_IDLE : RX_DATA;
            end else begin
              rx_tick_q <= rx_tick_q + 5'h01;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            if (rx_tick_q == last) begin
              rx_tick_q <= 5'h00;
              rx_sh_q <= {rec_line, rx_sh_q[7:1]};
              rx_bit_q <= rx_bit_q + 3'h1;
              if (rx_bit_q == LAST_DATA_BIT) begin
                rx_st_q <= RX_STOP;
              end
            end else begin
              rx_tick_q <= rx_tick_q + 5'h01;
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            if (rx_tick_q == last) begin
              rx_tick_q <= 5'h00;
              rx_st_q <= RX_IDLE;
            end else begin
              rx_tick_q <= rx_tick_q + 5'h01;
            end
          end
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  assign rx_end = rxe && tick && rx_st_q == RX_STOP && rx_tick_q == last;
  assign rx_ok_ev = rx_end && rec_line;
  assign rx_err_ev = rx_end && !rec_line;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rxb_q <= RXB_RST;
    end else if (rx_end) begin
      rxb_q <= rx_sh_q;
    end
  end

  // Sticky events, write one to clear, a new event wins
  assign ev = {rx_err_ev, rx_ok_ev, tx_done_ev};
  assign clr = (bus_req.we && bus_req.addr == ADR_IRQ_STAT) ? bus_req.wdata[IRQ_W-1:0] : 3'h0;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~clr) | ev;
    end
  end

  assign irq = |(stat_q & mask_q);

  // Read data stand for one cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst || !bus_req.re) begin
      rdata_q <= 8'h00;
    end else begin
      case (bus_req.addr)
        ADR_MODE: rdata_q <= mode_q;
        ADR_DIV: rdata_q <= div_q;
        ADR_TXD: rdata_q <= {7'h00, tx_st_q != TX_IDLE};
        ADR_RXB: rdata_q <= rxb_q;
        ADR_IRQ_STAT: rdata_q <= {5'h00, stat_q};
        ADR_IRQ_MASK: rdata_q <= {5'h00, mask_q};
        ADR_PORT: rdata_q <= {2'h0, txp_s2_q, rx_lvl, port_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  assign bus_rdata = rdata_q;
  assign serial_transmit_pin_drv = tx_drv_q;
  assign serial_receive_pin_drv = rx_drv_q;

  // Checking helpers
  logic [8:0] fr_ticks_q;
  logic [8:0] frame_ticks;
  logic [4:0] pw_q;

  assign frame_ticks = {4'h0, bit_len} * FRAME_SLOTS;

  always_ff @(posedge sys_clk) begin
    if (rst || tx_go) begin
      fr_ticks_q <= 9'h000;
    end else if (tick && tx_st_q != TX_IDLE) begin
      fr_ticks_q <= fr_ticks_q + 9'h001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst || !ir_pulse_c) begin
      pw_q <= 5'h00;
    end else if (tick) begin
      pw_q <= pw_q + 5'h01;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_tx_write;
    bus_req.we && bus_req.addr == ADR_TXD && txe && tx_st_q == TX_IDLE;
  endsequence

  sequence s_tx_begin;
    tx_st_q == TX_START && tx_tick_q == 5'h00;
  endsequence

  sequence s_start_check;
    rxe && !mode_wr && rx_st_q == RX_START && tick && rx_tick_q == half - 5'h01;
  endsequence

  chk_tx_start:
    assert property (s_tx_write |=> s_tx_begin)
    else $error("write to transmit register did not start a frame");

  chk_tx_frame_len:
    assert property (tx_done_ev |-> fr_ticks_q == frame_ticks - 9'h001)
    else $error("transmit frame is not ten bit slots long");

  chk_ir_pulse_width:
    assert property ($fell(ir_pulse_c) && txe && ir |-> pw_q == IR_PULSE_TICKS)
    else $error("infrared pulse is not three ticks wide");

  chk_pulse_mid_slot:
    assert property ($rose(ir_pulse_c) |-> tx_tick_q == half && !tx_level)
    else $error("infrared pulse did not start at mid slot");

  chk_stretch_len:
    assert property ($fell(str_act_q) && ir |-> $past(str_cnt_q) == last)
    else $error("recovered bit is not one bit time long");

  chk_ir_divider:
    assert property (ir && div_q == DIV_IR_VALUE |-> pre_mask == IR_PRESCALE_MASK && bit_len == TICKS_BASE)
    else $error("reference divider does not give a 64 cycle bit");

  chk_tx_port_pin:
    assert property (!txe && !mode_wr |=> tx_drv_q.out == $past(tx_lat) && tx_drv_q.oe == !$past(tx_dir))
    else $error("idle transmit pin does not follow port settings");

  chk_ir_idle_low:
    assert property (txe && ir && tx_level && !mode_wr |=> !tx_drv_q.out && tx_drv_q.oe)
    else $error("infrared output high during a one bit");

  chk_rx_gate:
    assert property (!rxe |=> rx_st_q == RX_IDLE && !rx_end)
    else $error("receiver ran while disabled");

  chk_start_check:
    assert property (s_start_check |=> rx_st_q == ($past(rec_line) ? RX_IDLE : RX_DATA))
    else $error("start bit confirmation wrong at half bit");

  chk_tx_done_irq:
    assert property (tx_done_ev |-> tx_level ##1 stat_q[IRQ_TX_DONE])
    else $error("transmit done not flagged after stop bit");
endmodule // uirm_top

// [pkg/uirm_pkg.sv]
// Package: register map, field positions, states and timing of the infrared UART
package uirm_pkg;
  // Register indices on the plain register port
  localparam logic [2:0] ADR_MODE = 3'h0;
  localparam logic [2:0] ADR_DIV = 3'h1;
  localparam logic [2:0] ADR_TXD = 3'h2;
  localparam logic [2:0] ADR_RXB = 3'h3;
  localparam logic [2:0] ADR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADR_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADR_PORT = 3'h6;
  // serial_mode_control fields
  localparam int MODE_TXE = 7;
  localparam int MODE_RXE = 6;
  localparam int MODE_IR = 0;
  // bit_rate_divider_control fields
  localparam int DIV_TPS_LSB = 4;
  localparam int DIV_MDL_LSB = 0;
  localparam logic [7:0] DIV_IR_VALUE = 8'h10;
  // Port control fields
  localparam int PORT_W = 4;
  localparam int PORT_RX_DIR = 0;
  localparam int PORT_TX_DIR = 1;
  localparam int PORT_TX_LAT = 2;
  localparam int PORT_RX_LAT = 3;
  // Interrupt status and mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_TX_DONE = 0;
  localparam int IRQ_RX_DONE = 1;
  localparam int IRQ_RX_ERR = 2;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [PORT_W-1:0] PORT_RST = 4'h3;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;
  localparam logic [7:0] RXB_RST = 8'hff;
  // Bit timing in sixteenth-bit ticks
  localparam logic [4:0] TICKS_BASE = 5'h10;
  localparam logic [4:0] IR_PULSE_TICKS = 5'h03;
  localparam logic [2:0] LAST_DATA_BIT = 3'h7;
  localparam logic [8:0] FRAME_SLOTS = 9'h00a;
  localparam logic [7:0] IR_PRESCALE_MASK = 8'h03;
  // Reference infrared operating point
  localparam int CLK_NS = 10;
  localparam int IR_REF_BAUD = 115200;
  localparam int IR_PULSE_NOM_NS = 1630;
  localparam int IR_PULSE_MIN_NS = 1410;
  localparam int IR_PULSE_MAX_NS = 2710;
  localparam int IR_PULSE_MIN_CYC = (IR_PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int IR_PULSE_MAX_CYC = IR_PULSE_MAX_NS / CLK_NS;
  // Receive noise filter: samples a new level must hold
  localparam logic [1:0] NF_SAMPLES = 2'h2;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } uirm_tx_st_t;

  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } uirm_rx_st_t;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } uirm_bus_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } uirm_pin_drv_t;
endpackage

// [rtl/uirm_rx_filter.sv]
// Receive pin synchroniser and digital noise filter
`timescale 1ns/100ps
module uirm_rx_filter
  import uirm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin_in,
  output logic level
);
  logic s1_q;
  logic s2_q;
  logic level_q;
  logic [1:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= pin_in;
      s2_q <= s1_q;
    end
  end

  // New level taken only after it held for the filter length
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_q <= 1'b1;
      cnt_q <= 2'h0;
    end else if (s2_q == level_q) begin
      cnt_q <= 2'h0;
    end else if (cnt_q == NF_SAMPLES - 2'h1) begin
      level_q <= s2_q;
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  assign level = level_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  chk_filter_stable:
    assert property ($changed(level_q) |-> $past(s2_q, 1) == level_q && $past(s2_q, 2) == level_q)
    else $error("filter passed a level held for too few samples");
endmodule // uirm_rx_filter

// [sim/uirm_ir_xcvr.sv]
// Infrared transceiver model: sends pulse frames and decodes transmitted pulses
`timescale 1ns/100ps
module uirm_ir_xcvr
  import uirm_pkg::*;
#(
  parameter int BIT_CYC = 64
)
(
  input wire logic sys_clk,
  input wire logic tx_line,
  input wire logic send,
  input wire logic [7:0] send_byte,
  input wire logic send_brk,
  input wire logic [7:0] pw,
  output logic rx_line,
  output logic got_valid,
  output logic [7:0] got_byte,
  output logic [7:0] got_width
);
  logic [9:0] frame;
  logic [7:0] dec;
  int w;
  initial begin
    rx_line = 1'b0;
    got_valid = 1'b0;
    got_byte = 8'h00;
    got_width = 8'h00;
  end
  // Pulse of pw cycles at mid slot for each zero-level bit, line low otherwise
  always @(posedge sys_clk) begin
    if (send) begin
      frame = {~send_brk, send_byte, 1'b0};
      for (int i = 0; i < 10; i++) begin
        if (frame[i]) begin
          repeat (BIT_CYC) @(posedge sys_clk);
        end else begin
          repeat (BIT_CYC / 2) @(posedge sys_clk);
          rx_line <= 1'b1;
          repeat (pw) @(posedge sys_clk);
          rx_line <= 1'b0;
          repeat (BIT_CYC / 2 - pw) @(posedge sys_clk);
        end
      end
    end
  end
  // Start pulse width measured, then each slot sampled mid-pulse; stop slot must stay dark
  always begin
    @(posedge tx_line);
    w = 0;
    do begin
      @(posedge sys_clk);
      if (tx_line) w++;
    end while (tx_line);
    repeat (BIT_CYC + 5 - w) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      dec[i] = ~tx_line;
      repeat (BIT_CYC) @(posedge sys_clk);
    end
    if (tx_line) w = 0;
    got_byte <= dec;
    got_width <= 8'(w);
    got_valid <= 1'b1;
    @(posedge sys_clk);
    got_valid <= 1'b0;
  end
endmodule // uirm_ir_xcvr

// [sim/tb_top.sv]
// Testbench of the infrared UART: registers, pulse transmit and receive, port sharing
`timescale 1ns/100ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top
  import uirm_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  uirm_bus_req_t bus_req = '0;
  logic [7:0] bus_rdata;
  uirm_pin_drv_t rx_drv;
  uirm_pin_drv_t tx_drv;
  logic irq;
  logic xrx;
  logic tx_wire;
  logic rx_wire;
  logic send = 1'b0;
  logic send_brk = 1'b0;
  logic got_valid;
  logic re_d = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] pw = 8'h0c;
  logic [7:0] got_byte;
  logic [7:0] got_width;
  logic [7:0] b;
  logic [7:0] exp_v;
  int fail_count = 0;
  int comparisons = 0;
  integer seed = 32'ha47ac246;
  logic [7:0] rd_q[$];
  logic [7:0] tx_q[$];

  // Transmit pin has a weak pull-down, receive pin follows the transceiver unless driven
  assign tx_wire = tx_drv.oe ? tx_drv.out : 1'b0;
  assign rx_wire = rx_drv.oe ? rx_drv.out : xrx;

  uirm_top dut (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_receive_pin_in(rx_wire), .serial_receive_pin_drv(rx_drv),
    .serial_transmit_pin_in(tx_wire), .serial_transmit_pin_drv(tx_drv), .irq(irq));

  uirm_ir_xcvr xcvr (.sys_clk(sys_clk), .tx_line(tx_wire), .send(send), .send_byte(send_byte),
    .send_brk(send_brk), .pw(pw), .rx_line(xrx), .got_valid(got_valid), .got_byte(got_byte),
    .got_width(got_width));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("Comparisons: %0d, mismatches: %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #500000;
    fail_count++;
    stop_test();
  end

  // Result watcher: read data and decoded frames against the oldest notes
  always @(posedge sys_clk) begin
    re_d <= bus_req.re;
    if (re_d) begin
      exp_v = (rd_q.size() != 0) ? rd_q.pop_front() : 8'hxx;
      `CHK(bus_rdata, exp_v)
    end
    if (got_valid) begin
      exp_v = (tx_q.size() != 0) ? tx_q.pop_front() : 8'hxx;
      `CHK(got_byte, exp_v)
      `CHK(got_width, 8'h0c)
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge sys_clk);
    bus_req.we <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    @(posedge sys_clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge sys_clk);
    bus_req.re <= 1'b0;
  endtask

  task automatic wait_irq(input int lo, input int hi);
    int k;
    k = 0;
    while (irq !== 1'b1 && k < hi) begin
      @(posedge sys_clk);
      k++;
    end
    `CHK(irq === 1'b1 && k >= lo, 1'b1)
  endtask

  initial begin
    cyc(8);
    rst <= 1'b0;
    cyc(8);
    rd(ADR_MODE, MODE_RST);
    rd(ADR_DIV, DIV_RST);
    rd(ADR_RXB, RXB_RST);
    rd(ADR_IRQ_MASK, 8'(MASK_RST));
    rd(ADR_IRQ_STAT, 8'h00);
    rd(ADR_PORT, 8'(PORT_RST));
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    b = 8'($random(seed)) & 8'h3e;
    wr(ADR_MODE, b);
    rd(ADR_MODE, b);
    b = 8'($random(seed));
    wr(ADR_DIV, b);
    rd(ADR_DIV, b);
    wr(ADR_DIV, DIV_IR_VALUE);
    wr(ADR_IRQ_MASK, 8'h01);
    wr(ADR_MODE, 8'hc1);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
      tx_q.push_back(b);
      wr(ADR_TXD, b);
      rd(ADR_TXD, 8'h01);
      wr(ADR_TXD, ~b);
      wait_irq(600, 700);
      rd(ADR_IRQ_STAT, 8'h01);
      wr(ADR_IRQ_STAT, 8'h01);
      cyc(2);
      `CHK(irq, 1'b0)
      rd(ADR_TXD, 8'h00);
    end
    // Unused pin as port output
    wr(ADR_MODE, 8'h81);
    wr(ADR_PORT, 8'h08);
    cyc(2);
    `CHK(rx_drv, 2'b11)
    // Driven high level looks like a pulse: let its recovered bit run out before receive is enabled
    wr(ADR_PORT, 8'h01);
    cyc(100);
    wr(ADR_MODE, 8'h41);
    cyc(2);
    `CHK(tx_drv, 2'b01)
    wr(ADR_TXD, 8'h5a);
    cyc(700);
    rd(ADR_IRQ_STAT, 8'h00);
    wr(ADR_IRQ_MASK, 8'h00);
    for (int i = 0; i < 3; i++) begin
      b = (i == 0) ? 8'h55 : (i == 1) ? 8'($random(seed)) : 8'ha3;
      @(posedge sys_clk);
      send_byte <= b;
      send_brk <= (i == 2);
      pw <= (i == 1) ? 8'h04 : 8'h0c;
      send <= 1'b1;
      @(posedge sys_clk);
      send <= 1'b0;
      cyc(720);
      `CHK(irq, 1'b0)
      rd(ADR_RXB, b);
      rd(ADR_IRQ_STAT, (i == 2) ? 8'h04 : 8'h02);
      wr(ADR_IRQ_MASK, 8'h06);
      cyc(2);
      `CHK(irq, 1'b1)
      wr(ADR_IRQ_STAT, 8'h07);
      wr(ADR_IRQ_MASK, 8'h00);
      cyc(2);
      `CHK(irq, 1'b0)
    end
    cyc(4);
    `CHK(tx_q.size(), 0)
    stop_test();
  end
endmodule // tb_top
